/* rtl/mlp_term_adapt.sv */
// Linear protection trail termination and protection layer adaptation, both directions.
`timescale 1ns/1ps
module mlp_term_adapt #(
  parameter logic [15:0] K1_POS        = mlp_pkg::K1_POS_DEF,
  parameter bit          IS_PROTECTION = 1'b1,
  parameter int          FIFO_DEPTH    = mlp_pkg::FIFO_DEPTH
) (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // Termination source, access side in, connection side out.
  input  wire logic                          ts_access_data,
  input  wire logic                          ts_access_clk,
  input  wire logic                          ts_access_fs,
  output logic                               ts_protection_conn_data,
  output logic                               ts_protection_conn_clk,
  output logic                               ts_protection_conn_fs,
  // Termination sink.
  input  wire logic                          tk_protection_conn_data,
  input  wire logic                          tk_protection_conn_clk,
  input  wire logic                          tk_protection_conn_fs,
  input  wire logic                          server_fail_in,
  input  wire logic                          fail_report_enable,
  output logic                               tk_section_access_data,
  output logic                               tk_section_access_clk,
  output logic                               tk_section_access_fs,
  output logic                               trail_fail_ind,
  output logic                               correlated_fail_report,
  // Adaptation source.
  input  wire logic                          as_protection_conn_data,
  input  wire logic                          as_protection_conn_clk,
  input  wire logic                          as_protection_conn_fs,
  input  wire logic [mlp_pkg::APS_BITS-1:0]  switch_bytes_in,
  output logic                               as_section_access_data,
  output logic                               as_section_access_clk,
  output logic                               as_section_access_fs,
  // Adaptation sink.
  input  wire logic                          ak_section_access_data,
  input  wire logic                          ak_section_access_clk,
  input  wire logic                          ak_section_access_fs,
  input  wire logic                          section_trail_fail,
  input  wire logic                          trail_degrade_ind,
  input  wire logic                          switch_accept_stall,
  output logic                               ak_protection_conn_data,
  output logic                               ak_protection_conn_clk,
  output logic                               ak_protection_conn_fs,
  output logic [mlp_pkg::APS_BITS-1:0]       switch_bytes_out,
  output logic                               server_fail_action,
  output logic                               server_degrade_action,
  output logic                               switch_capture_drop
);

  import mlp_pkg::*;

  // ---------------------------------------------------------------
  // Synchronise all twelve pin inputs: per path {fs, clk, data}.
  // ---------------------------------------------------------------
  wire  [3*PATHS-1:0] pins_async;
  logic [3*PATHS-1:0] pins_sync;

  assign pins_async = {ak_section_access_fs, ak_section_access_clk, ak_section_access_data,
                       as_protection_conn_fs, as_protection_conn_clk, as_protection_conn_data,
                       tk_protection_conn_fs, tk_protection_conn_clk, tk_protection_conn_data,
                       ts_access_fs, ts_access_clk, ts_access_data};

  mlp_sync #(
    .W (3*PATHS)
  ) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d_async (pins_async),
    .d_sync  (pins_sync)
  );

  wire [PATHS-1:0] data_s;
  wire [PATHS-1:0] clk_s;
  wire [PATHS-1:0] fs_s;

  genvar gi;
  generate
    for (gi = 0; gi < PATHS; gi++) begin : g_split
      assign data_s[gi] = pins_sync[3*gi];
      assign clk_s[gi]  = pins_sync[3*gi+1];
      assign fs_s[gi]   = pins_sync[3*gi+2];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Output staging. Data and frame start leave one cycle ahead of the
  // clock copy, so the far end sees them settled at its clock edge.
  // ---------------------------------------------------------------
  logic [PATHS-1:0] data_out_reg;
  logic [PATHS-1:0] data_out_next;
  logic [PATHS-1:0] fs_out_reg;
  // The clock copy passes two registers, so it trails data by one cycle.
  logic [PATHS-1:0] clk_dly_reg;
  logic [PATHS-1:0] clk_out_reg;
  logic [PATHS-1:0] clk_prev_reg;

  wire  [PATHS-1:0] clk_rise = clk_s & ~clk_prev_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      data_out_reg <= '0;
      fs_out_reg   <= '0;
      clk_dly_reg  <= '0;
      clk_out_reg  <= '0;
      clk_prev_reg <= '0;
    end else begin
      data_out_reg <= data_out_next;
      fs_out_reg   <= fs_s;
      clk_dly_reg  <= clk_s;
      clk_out_reg  <= clk_dly_reg;
      clk_prev_reg <= clk_s;
    end
  end

  assign ts_protection_conn_data = data_out_reg[PATH_TS];
  assign ts_protection_conn_clk  = clk_out_reg[PATH_TS];
  assign ts_protection_conn_fs   = fs_out_reg[PATH_TS];
  assign tk_section_access_data  = data_out_reg[PATH_TK];
  assign tk_section_access_clk   = clk_out_reg[PATH_TK];
  assign tk_section_access_fs    = fs_out_reg[PATH_TK];
  assign as_section_access_data  = data_out_reg[PATH_AS];
  assign as_section_access_clk   = clk_out_reg[PATH_AS];
  assign as_section_access_fs    = fs_out_reg[PATH_AS];
  assign ak_protection_conn_data = data_out_reg[PATH_AK];
  assign ak_protection_conn_clk  = clk_out_reg[PATH_AK];
  assign ak_protection_conn_fs   = fs_out_reg[PATH_AK];

  // ---------------------------------------------------------------
  // Bit position within the frame, for the adaptation source and sink.
  // The index is zero on the bit sampled with frame start high and
  // saturates, so a missing frame start never wraps into the K window.
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] as_idx_reg;
  logic [IDX_W-1:0] ak_idx_reg;
  wire  [IDX_W-1:0] as_idx_cur;
  wire  [IDX_W-1:0] ak_idx_cur;

  assign as_idx_cur = fs_s[PATH_AS] ? '0 :
                      (as_idx_reg == IDX_MAX) ? IDX_MAX : IDX_W'(as_idx_reg + 1'b1);
  assign ak_idx_cur = fs_s[PATH_AK] ? '0 :
                      (ak_idx_reg == IDX_MAX) ? IDX_MAX : IDX_W'(ak_idx_reg + 1'b1);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      as_idx_reg <= IDX_MAX;
      ak_idx_reg <= IDX_MAX;
    end else begin
      if (clk_rise[PATH_AS]) begin
        as_idx_reg <= as_idx_cur;
      end
      if (clk_rise[PATH_AK]) begin
        ak_idx_reg <= ak_idx_cur;
      end
    end
  end

  // ---------------------------------------------------------------
  // Adaptation source: overwrite K1[1-8] and K2[1-5] in the passing
  // stream with the switching word, MSB (K1 bit 1) first.
  // ---------------------------------------------------------------
  // On the cycle of a link clock rise the new index is used at once, so a
  // replaced bit leaves a full cycle ahead of the copied clock edge.
  wire [IDX_W-1:0] as_idx_eff = clk_rise[PATH_AS] ? as_idx_cur : as_idx_reg;
  wire [IDX_W-1:0] as_off     = IDX_W'(as_idx_eff - K1_POS);
  wire             as_in_kwin = (as_idx_eff >= K1_POS) && (as_off < IDX_W'(APS_BITS));
  wire [3:0]       as_bit_sel = 4'(APS_BITS - 1) - as_off[3:0];
  wire             as_bit     = as_in_kwin ? switch_bytes_in[as_bit_sel] : data_s[PATH_AS];

  always_comb begin
    data_out_next          = data_s;
    data_out_next[PATH_AS] = as_bit;
  end

  // ---------------------------------------------------------------
  // Adaptation sink: shift the 13 switching bits out of each frame and
  // queue the finished word for the acceptance stage.
  // ---------------------------------------------------------------
  wire [IDX_W-1:0] ak_off     = IDX_W'(ak_idx_cur - K1_POS);
  wire             ak_in_kwin = (ak_idx_cur >= K1_POS) && (ak_off < IDX_W'(APS_BITS));
  wire             ak_kbit    = IS_PROTECTION && clk_rise[PATH_AK] && ak_in_kwin;
  wire             ak_klast   = ak_kbit && (ak_off == IDX_W'(APS_BITS - 1));

  // Working instances never shift, so their queue stays empty.
  logic [APS_BITS-1:0] cap_shift_reg;
  logic                cap_valid_reg;
  logic                fifo_in_ready;
  logic                drop_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cap_shift_reg <= APS_RESET;
      cap_valid_reg <= 1'b0;
      drop_reg      <= 1'b0;
    end else begin
      if (ak_kbit) begin
        cap_shift_reg <= {cap_shift_reg[APS_BITS-2:0], data_s[PATH_AK]};
      end
      cap_valid_reg <= ak_klast;
      // A full queue refuses the word; the frame is lost and flagged.
      drop_reg      <= cap_valid_reg && !fifo_in_ready;
    end
  end

  // The drop pulse lets a user count lost frames; it does not stop acceptance.
  assign switch_capture_drop = drop_reg;

  logic                fifo_out_valid;
  logic [APS_BITS-1:0] fifo_out_data;
  wire                 accept_ready = !switch_accept_stall;

  // The stall input is back-pressure only; while it is held, words pile up in the queue.
  mlp_fifo #(
    .W     (APS_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (cap_valid_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (cap_shift_reg),
    .out_valid (fifo_out_valid),
    .out_ready (accept_ready),
    .out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------
  // Acceptance: a word becomes current after arriving in three
  // consecutive frames; any different word restarts the count at one.
  // ---------------------------------------------------------------
  // Words lost to a full queue do not break a run: the count only sees words
  // that reach this stage. This keeps the stage simple, at the cost of calling
  // two words consecutive when a frame between them was dropped.
  logic [APS_BITS-1:0] cand_reg;
  logic [CNT_W-1:0]    match_cnt_reg;
  logic [APS_BITS-1:0] accepted_reg;

  wire                 take      = fifo_out_valid && accept_ready;
  wire                 same      = (fifo_out_data == cand_reg) && (match_cnt_reg != '0);
  wire [CNT_W-1:0]     cnt_next  = !same ? CNT_ONE :
                                   (match_cnt_reg == CNT_ACCEPT) ? CNT_ACCEPT :
                                   CNT_W'(match_cnt_reg + 1'b1);
  wire                 accept_now = take && (cnt_next == CNT_ACCEPT);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cand_reg      <= APS_RESET;
      match_cnt_reg <= '0;
      accepted_reg  <= APS_RESET;
    end else begin
      if (take) begin
        cand_reg      <= fifo_out_data;
        match_cnt_reg <= cnt_next;
      end
      if (accept_now) begin
        accepted_reg <= fifo_out_data;
      end
    end
  end

  // Working-section instances tie the switching output low.
  assign switch_bytes_out = IS_PROTECTION ? accepted_reg : APS_RESET;

  // ---------------------------------------------------------------
  // Fail and degrade indications; all come from same-clock logic.
  // ---------------------------------------------------------------
  // Each indication is one register deep, so all four answer in the same cycle.
  logic tsf_reg;
  logic correlated_fail_report_reg;
  logic ssf_reg;
  logic ssd_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tsf_reg  <= 1'b0;
      correlated_fail_report_reg <= 1'b0;
      ssf_reg  <= 1'b0;
      ssd_reg  <= 1'b0;
    end else begin
      tsf_reg  <= server_fail_in;
      correlated_fail_report_reg <= server_fail_in && fail_report_enable;
      ssf_reg  <= section_trail_fail;
      ssd_reg  <= trail_degrade_ind;
    end
  end

  assign trail_fail_ind         = tsf_reg;
  assign correlated_fail_report = correlated_fail_report_reg;
  assign server_fail_action     = ssf_reg;
  assign server_degrade_action  = ssd_reg;

endmodule

/* rtl/mlp_pkg.sv */
// Shared constants for the linear protection termination and adaptation block.
package mlp_pkg;

  localparam int          SYNC_STAGES   = 2;
  localparam int          APS_BITS      = 13;
  localparam int          K1_BITS       = 8;
  localparam int          K2_BITS       = 5;
  localparam int          ACCEPT_FRAMES = 3;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          IDX_W         = 16;
  localparam int          CNT_W         = 2;
  localparam int          PATHS         = 4;
  localparam int          PATH_TS       = 0;
  localparam int          PATH_TK       = 1;
  localparam int          PATH_AS       = 2;
  localparam int          PATH_AK       = 3;
  localparam logic [15:0] K1_POS_DEF    = 16'h0040;
  localparam logic [15:0] IDX_MAX       = 16'hffff;
  localparam logic [12:0] APS_RESET     = 13'h0000;
  localparam logic [1:0]  CNT_ONE       = 2'h1;
  localparam logic [1:0]  CNT_ACCEPT    = 2'h3;

endpackage

/* rtl/mlp_sync.sv */
// Two-stage synchroniser for a bundle of independent asynchronous levels.
`timescale 1ns/1ps
module mlp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] d_sync
);

  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      d_sync   <= '0;
    end else begin
      meta_reg <= d_async;
      d_sync   <= meta_reg;
    end
  end

endmodule

/* rtl/mlp_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module mlp_fifo #(
  parameter int W     = 13,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;
  wire [AW-1:0]  wr_ptr_next;
  wire [AW-1:0]  rd_ptr_next;

  assign in_ready    = (count_reg != CW'(DEPTH));
  assign out_valid   = (count_reg != '0);
  assign out_data    = mem_reg[rd_ptr_reg];
  assign wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_reg + 1'b1);
  assign rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_reg + 1'b1);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_next;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_next;
      end
      if (push && !pop) begin
        count_reg <= CW'(count_reg + 1'b1);
      end else if (pop && !push) begin
        count_reg <= CW'(count_reg - 1'b1);
      end
    end
  end

  // Storage needs no reset; empty flags guard every read.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

endmodule

/* tb/mlp_term_adapt_asserts.sv */
// Concurrent checks on the ports of the protection termination and adaptation block.
`timescale 1ns/1ps
module mlp_term_adapt_chk #(
  parameter bit IS_PROTECTION = 1'b1
) (
  input wire logic                         clk_sys,
  input wire logic                         nrst,
  input wire logic                         ts_access_data,
  input wire logic                         ts_access_clk,
  input wire logic                         ts_access_fs,
  input wire logic                         ts_protection_conn_data,
  input wire logic                         ts_protection_conn_clk,
  input wire logic                         ts_protection_conn_fs,
  input wire logic                         tk_protection_conn_data,
  input wire logic                         tk_protection_conn_clk,
  input wire logic                         tk_protection_conn_fs,
  input wire logic                         tk_section_access_data,
  input wire logic                         tk_section_access_clk,
  input wire logic                         tk_section_access_fs,
  input wire logic                         as_protection_conn_clk,
  input wire logic                         as_protection_conn_fs,
  input wire logic                         as_section_access_clk,
  input wire logic                         as_section_access_fs,
  input wire logic                         ak_section_access_data,
  input wire logic                         ak_section_access_clk,
  input wire logic                         ak_section_access_fs,
  input wire logic                         ak_protection_conn_data,
  input wire logic                         ak_protection_conn_clk,
  input wire logic                         ak_protection_conn_fs,
  input wire logic                         server_fail_in,
  input wire logic                         fail_report_enable,
  input wire logic                         trail_fail_ind,
  input wire logic                         correlated_fail_report,
  input wire logic                         section_trail_fail,
  input wire logic                         trail_degrade_ind,
  input wire logic                         switch_accept_stall,
  input wire logic [mlp_pkg::APS_BITS-1:0] switch_bytes_out,
  input wire logic                         server_fail_action,
  input wire logic                         server_degrade_action,
  input wire logic                         switch_capture_drop
);
  import mlp_pkg::*;
  wire [7:0] path_in  = {tk_protection_conn_data, tk_protection_conn_clk, tk_protection_conn_fs,
                         ak_section_access_data, ak_section_access_clk, ak_section_access_fs,
                         as_protection_conn_clk, as_protection_conn_fs};
  wire [7:0] path_out = {tk_section_access_data, tk_section_access_clk, tk_section_access_fs,
                         ak_protection_conn_data, ak_protection_conn_clk, ak_protection_conn_fs,
                         as_section_access_clk, as_section_access_fs};
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // Pins are asynchronous, so the copy is only judged once the pipeline has settled.
  chk_ts_copy: assert property ($stable({ts_access_data, ts_access_clk, ts_access_fs})[*6]
    |-> {ts_protection_conn_data, ts_protection_conn_clk, ts_protection_conn_fs}
        == {ts_access_data, ts_access_clk, ts_access_fs})
    else $error("termination source copy differs from its input");
  chk_path_copy: assert property ($stable(path_in)[*6] |-> path_out == path_in)
    else $error("pass-through path differs from its input");
  chk_trail_fail: assert property ($changed(server_fail_in)
    |=> trail_fail_ind == $past(server_fail_in)) else $error("trail fail does not follow");
  chk_corr_cause: assert property (correlated_fail_report
    |-> $past(server_fail_in & fail_report_enable)) else $error("report without cause");
  chk_corr_set: assert property ((server_fail_in & fail_report_enable)[*2]
    |-> correlated_fail_report) else $error("report missing");
  chk_fail_action: assert property ($changed({section_trail_fail, trail_degrade_ind})
    |=> {server_fail_action, server_degrade_action}
        == $past({section_trail_fail, trail_degrade_ind})) else $error("actions do not follow");
  chk_stall_hold: assert property (switch_accept_stall[*3]
    |=> $stable(switch_bytes_out)) else $error("accepted value moved while stalled");
  chk_drop_pulse: assert property (switch_capture_drop
    |=> !switch_capture_drop) else $error("drop flag longer than one cycle");
  chk_working_zero: assert property (!IS_PROTECTION
    |-> switch_bytes_out == 13'h0000) else $error("working instance shows switching bits");
endmodule

bind mlp_term_adapt mlp_term_adapt_chk #(.IS_PROTECTION(IS_PROTECTION)) chk_u (.*);

/* tb/mlp_link_model.sv */
// Behavioural far-side section adaptation that sends framed serial data with clock and start.
`timescale 1ns/1ps
module mlp_link_model #(
  parameter logic [15:0] K1_POS = 16'h0004,
  parameter int          FRAME  = 20
) (
  output logic lk_clk,
  output logic lk_fs,
  output logic lk_dat
);
  initial begin
    lk_clk = 1'b0;
    lk_fs = 1'b0;
    lk_dat = 1'b0;
  end

  // Data moves mid low phase, so it is settled two system cycles either side of the rise.
  task automatic send(input logic [12:0] k);
    int j;
    #37;
    for (int i = 0; i < FRAME; i++) begin
      j = i - int'(K1_POS);
      lk_fs = (i == 0);
      lk_dat = (j >= 0 && j < 13) ? k[12-j] : i[1];
      #200 lk_clk = 1'b1;
      #400 lk_clk = 1'b0;
      #200;
    end
    // The clock stands still between frames and the idle line is not left at the last bit.
    lk_fs = 1'b0;
    lk_dat = ~lk_dat;
  endtask
endmodule

/* tb/tb_mlp_term_adapt.sv */
// Self-checking bench for the protection termination and adaptation block.
`timescale 1ns/1ps
module tb_mlp_term_adapt;
  import mlp_pkg::*;
  localparam logic [15:0] KP = 16'h0004;
  logic        clk_sys = 1'b0, nrst = 1'b0, server_fail_in = 1'b0, fail_report_enable = 1'b0;
  logic        section_trail_fail = 1'b0, trail_degrade_ind = 1'b0, switch_accept_stall = 1'b0;
  logic [12:0] switch_bytes_in = 13'h0000, acap = 13'h0000;
  logic [15:0] ai = 16'hffff;
  logic        ad_q = 1'b0;
  wire  [12:0] sbo_w;
  int          n_mismatch = 0, n_checks = 0, nd = 0;
  wire         lk_clk, lk_fs, lk_dat;
  wire         ts_access_data = lk_dat, ts_access_clk = lk_clk, ts_access_fs = lk_fs;
  wire         tk_protection_conn_data = lk_dat, tk_protection_conn_clk = lk_clk;
  wire         tk_protection_conn_fs = lk_fs, as_protection_conn_data = lk_dat;
  wire         as_protection_conn_clk = lk_clk, as_protection_conn_fs = lk_fs;
  wire         ak_section_access_data = lk_dat, ak_section_access_clk = lk_clk;
  wire         ak_section_access_fs = lk_fs;
  wire         ts_protection_conn_data, ts_protection_conn_clk, ts_protection_conn_fs;
  wire         tk_section_access_data, tk_section_access_clk, tk_section_access_fs;
  wire         trail_fail_ind, correlated_fail_report, server_fail_action;
  wire         as_section_access_data, as_section_access_clk, as_section_access_fs;
  wire         ak_protection_conn_data, ak_protection_conn_clk, ak_protection_conn_fs;
  wire         server_degrade_action, switch_capture_drop;
  wire [12:0]  switch_bytes_out;
  wire [3:0]   fail_outs = {trail_fail_ind, correlated_fail_report, server_fail_action,
                            server_degrade_action};
  wire [31:0]  all_outs = {switch_bytes_out, fail_outs, switch_capture_drop, ts_protection_conn_data,
                           ts_protection_conn_clk, ts_protection_conn_fs, tk_section_access_data,
                           tk_section_access_clk, tk_section_access_fs, as_section_access_data,
                           as_section_access_clk, as_section_access_fs, ak_protection_conn_data,
                           ak_protection_conn_clk, ak_protection_conn_fs, 2'h0};
  // Rows: four fail inputs, then trail fail, report, fail action and degrade action.
  logic [7:0]  rows [8] = '{8'hcc, 8'h88, 8'h40, 8'h22, 8'h11, 8'hff, 8'hbb, 8'h00};
  // Rows: word sent in the frame, then the accepted value expected after it.
  logic [25:0] acc [9] = '{{13'h1a5c, 13'h0000}, {13'h1a5c, 13'h0000}, {13'h1a5c, 13'h1a5c},
                           {13'h0b37, 13'h1a5c}, {13'h0b37, 13'h1a5c}, {13'h1a5c, 13'h1a5c},
                           {13'h0b37, 13'h1a5c}, {13'h0b37, 13'h1a5c}, {13'h0b37, 13'h0b37}};

  mlp_term_adapt #(.K1_POS(KP)) dut_u (.*);
  // A working-section copy shares every input and must never show switching bits.
  mlp_term_adapt #(.K1_POS(KP), .IS_PROTECTION(1'b0)) dut_w (.*,
    .ts_protection_conn_data(), .ts_protection_conn_clk(), .ts_protection_conn_fs(),
    .tk_section_access_data(), .tk_section_access_clk(), .tk_section_access_fs(),
    .trail_fail_ind(), .correlated_fail_report(), .as_section_access_data(),
    .as_section_access_clk(), .as_section_access_fs(), .ak_protection_conn_data(),
    .ak_protection_conn_clk(), .ak_protection_conn_fs(), .switch_bytes_out(sbo_w),
    .server_fail_action(), .server_degrade_action(), .switch_capture_drop());
  mlp_link_model #(.K1_POS(KP)) lm_u (.lk_clk(lk_clk), .lk_fs(lk_fs), .lk_dat(lk_dat));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // Rebuilds the outgoing switching span from the output clock, independent of the design.
  // Each bit is taken half a system cycle before the clock rises, so late data shows.
  always @(negedge clk_sys) ad_q = as_section_access_data;
  always @(posedge as_section_access_clk) begin
    ai = as_section_access_fs ? 16'h0000 : (ai == 16'hffff ? ai : ai + 16'h0001);
    if (ai >= KP && ai < KP + 16'h000d) acap = {acap[11:0], ad_q};
  end

  always @(posedge clk_sys) begin
    if (switch_capture_drop === 1'b1) nd++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The inserted word is the inverse of the link's own, so a missing insertion shows.
  task automatic frame(input logic [12:0] k);
    @(negedge clk_sys);
    switch_bytes_in = ~k;
    lm_u.send(k);
    repeat (10) @(negedge clk_sys);
    chk("insert", 32'(acap), 32'(switch_bytes_in));
  endtask

  initial begin
    #2000000;
    n_mismatch++;
    end_of_test;
  end

  initial begin
    repeat (20) @(negedge clk_sys);
    chk("reset", all_outs, 32'h0);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      {server_fail_in, fail_report_enable, section_trail_fail, trail_degrade_ind} = rows[i][7:4];
      @(negedge clk_sys);
      chk("fail", 32'(fail_outs), 32'(rows[i][3:0]));
    end
    for (int i = 0; i < 9; i++) begin
      frame(acc[i][25:13]);
      chk("accept", 32'(switch_bytes_out), 32'(acc[i][12:0]));
    end
    chk("working", 32'(sbo_w), 32'h0);
    switch_accept_stall = 1'b1;
    repeat (9) frame(13'h1fff);
    chk("drop", 32'(nd), 32'h1);
    chk("held", 32'(switch_bytes_out), 32'h0b37);
    switch_accept_stall = 1'b0;
    repeat (40) @(negedge clk_sys);
    chk("drain", 32'(switch_bytes_out), 32'h1fff);
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("midreset", all_outs, 32'h0);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    frame(13'h1fff);
    chk("restart", 32'(switch_bytes_out), 32'h0);
    end_of_test;
  end
endmodule
